/* File: design/pll_ctrl_pkg.sv */
// constants and types for the pll clock switchover control block
package pll_ctrl_pkg;

    localparam int CLK_PERIOD_NS  = 4;
    localparam int RST_HOLD_NS    = 10;
    localparam int RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAULT_IDLE_CYC = 16;
    localparam int SCAN_HALF_CYC  = 2;
    localparam int SCAN_STEP_CYC  = 2 * SCAN_HALF_CYC;

    localparam int NUM_GLOBAL_CLOCK_NET_MAX     = 30;
    localparam int NUM_PLL_MAX      = 8;
    localparam int NUM_OUT_COUNTERS = 5;
    localparam int NUM_CCB_PER_SIDE = 5;
    localparam int NUM_TAPS         = 8;
    localparam int TAP_W            = 3;
    localparam int COARSE_W         = 8;
    localparam int CNT_IDX_W        = 3;

    localparam int NUM_DEDICATED    = 4;
    localparam int NUM_PLL_OUTS     = 10;
    localparam int NUM_DUAL_PURPOSE_CLOCK_PIN        = 6;
    localparam int NUM_INTERNAL     = 5;
    localparam int NUM_CORNER_PINS  = 4;
    localparam int NUM_CCB_SRC      = NUM_DEDICATED + NUM_PLL_OUTS + NUM_DUAL_PURPOSE_CLOCK_PIN + NUM_INTERNAL;
    localparam int SRC_SEL_W        = 5;

    localparam logic [TAP_W-1:0]    TAP_RESET    = 3'h0;
    localparam logic [TAP_W-1:0]    TAP_LAST     = 3'h7;
    localparam logic [COARSE_W-1:0] COARSE_RESET = 8'h01;
    localparam logic [COARSE_W-1:0] COARSE_MIN   = 8'h01;

    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_SWITCH = 4'b0010,
        ST_RESET  = 4'b0100,
        ST_RELOCK = 4'b1000
    } sw_state_t;

    typedef struct packed {
        logic                 req;
        logic                 up;
        logic [CNT_IDX_W-1:0] counter;
    } phase_cmd_t;

    typedef struct packed {
        logic primary_fault;
        logic secondary_fault;
        logic on_secondary;
        logic relocking;
        logic phase_busy;
    } pll_status_t;

endpackage : pll_ctrl_pkg

/* File: design/pll_switchover_ctrl.sv */
// pll reference switchover, fault monitor, phase stepping and clock source selection
`timescale 1ns/100ps
`default_nettype none

module pll_switchover_ctrl
    import pll_ctrl_pkg::*;
#(
    parameter int NUM_CCB = NUM_CCB_PER_SIDE
) (
    input  wire logic                                 clock_i,
    input  wire logic                                 nrst_i,
    input  wire logic                                 primary_ref_clock_i,
    input  wire logic                                 secondary_ref_clock_i,
    input  wire logic                                 manual_switch_i,
    input  wire logic                                 auto_switch_en_i,
    input  wire logic                                 pfd_enable_i,
    input  wire logic                                 pll_locked_i,
    input  wire logic [NUM_OUT_COUNTERS-1:0]          out_clock_enable_i,
    input  wire phase_cmd_t                           phase_cmd_i,
    input  wire logic                                 coarse_load_i,
    input  wire logic [CNT_IDX_W-1:0]                 coarse_counter_i,
    input  wire logic [COARSE_W-1:0]                  coarse_value_i,
    input  wire logic [NUM_DEDICATED-1:0]             dedicated_clock_pin_i,
    input  wire logic [NUM_PLL_OUTS-1:0]              pll_counter_out_i,
    input  wire logic [NUM_DUAL_PURPOSE_CLOCK_PIN-1:0]                 dual_purpose_clock_pin_i,
    input  wire logic [NUM_CORNER_PINS-1:0]           corner_dual_purpose_clock_pin_i,
    input  wire logic [1:0]                           corner_sel_i,
    input  wire logic [NUM_INTERNAL-1:0]              internal_clock_i,
    input  wire logic [NUM_CCB*SRC_SEL_W-1:0]         ccb_src_sel_i,
    output logic                                      ref_select_o,
    output logic                                      pll_reset_o,
    output logic                                      pfd_enable_o,
    output logic [NUM_OUT_COUNTERS-1:0]               out_clock_gate_o,
    output logic                                      primary_clock_fault_o,
    output logic                                      secondary_clock_fault_o,
    output logic                                      phase_ready_o,
    output logic                                      phase_done_o,
    output logic                                      scan_clk_o,
    output logic [NUM_OUT_COUNTERS*TAP_W-1:0]         phase_tap_o,
    output logic [NUM_OUT_COUNTERS*COARSE_W-1:0]      coarse_start_o,
    output logic [NUM_CCB-1:0]                        global_clock_net_o,
    output logic [NUM_CORNER_PINS-1:0]                corner_gpio_o,
    output pll_status_t                               status_o
);

    function automatic logic pick_src(input logic [NUM_CCB_SRC-1:0] src,
                                      input logic [SRC_SEL_W-1:0]   sel);
        logic r;
        r = 1'b0;
        if (int'(sel) < NUM_CCB_SRC) begin
            r = src[sel];
        end
        return r;
    endfunction : pick_src

    ////////////////////////////////////////////////////////////////////////////
    // reference clock fault monitor
    logic [1:0] sync_a_ff, sync_b_ff, last_ff, fault_ff;
    logic [1:0] nxt_sync_a, nxt_sync_b, nxt_last, nxt_fault;
    logic [4:0] idle_cnt_ff [2];
    logic [4:0] nxt_idle_cnt [2];

    always_comb begin
        nxt_sync_a = {secondary_ref_clock_i, primary_ref_clock_i};
        nxt_sync_b = sync_a_ff;
        nxt_last   = sync_b_ff;
        for (int i = 0; i < 2; i++) begin
            nxt_idle_cnt[i] = idle_cnt_ff[i];
            nxt_fault[i]    = fault_ff[i];
            if (sync_b_ff[i] != last_ff[i]) begin
                nxt_idle_cnt[i] = 5'h00;
                nxt_fault[i]    = 1'b0;
            end else if (int'(idle_cnt_ff[i]) == FAULT_IDLE_CYC - 1) begin
                nxt_fault[i]    = 1'b1;
            end else begin
                nxt_idle_cnt[i] = idle_cnt_ff[i] + 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a_ff      <= 2'h0;
            sync_b_ff      <= 2'h0;
            last_ff        <= 2'h0;
            fault_ff       <= 2'h0;
            idle_cnt_ff[0] <= 5'h00;
            idle_cnt_ff[1] <= 5'h00;
        end else begin
            sync_a_ff      <= nxt_sync_a;
            sync_b_ff      <= nxt_sync_b;
            last_ff        <= nxt_last;
            fault_ff       <= nxt_fault;
            idle_cnt_ff[0] <= nxt_idle_cnt[0];
            idle_cnt_ff[1] <= nxt_idle_cnt[1];
        end
    end

    assign primary_clock_fault_o   = fault_ff[0];
    assign secondary_clock_fault_o = fault_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // switchover state machine, pll reset and output gating
    sw_state_t                   state_ff, nxt_state;
    logic                        ref_sel_ff, nxt_ref_sel;
    logic                        rst_ff, nxt_rst;
    logic [1:0]                  rst_cnt_ff, nxt_rst_cnt;
    logic                        pfd_ff, nxt_pfd;
    logic [NUM_OUT_COUNTERS-1:0] gate_ff, nxt_gate;
    logic                        auto_go, manual_go;

    // automatic switching only moves off a failed primary onto a healthy secondary
    assign auto_go   = auto_switch_en_i & ~ref_sel_ff & fault_ff[0] & ~fault_ff[1];
    assign manual_go = manual_switch_i;

    always_comb begin
        nxt_state   = state_ff;
        nxt_ref_sel = ref_sel_ff;
        nxt_rst     = 1'b0;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_pfd     = pfd_enable_i;
        nxt_gate    = out_clock_enable_i;
        case (state_ff)
            ST_RUN: begin
                if (manual_go || auto_go) begin
                    nxt_state   = ST_SWITCH;
                    nxt_ref_sel = ~ref_sel_ff;
                    nxt_gate    = '0;
                end
            end
            ST_SWITCH: begin
                nxt_state   = ST_RESET;
                nxt_rst     = 1'b1;
                nxt_rst_cnt = 2'h0;
                nxt_gate    = '0;
            end
            ST_RESET: begin
                nxt_gate = '0;
                if (int'(rst_cnt_ff) == RST_HOLD_CYC - 1) begin
                    nxt_state = ST_RELOCK;
                end else begin
                    nxt_rst     = 1'b1;
                    nxt_rst_cnt = rst_cnt_ff + 2'h1;
                end
            end
            ST_RELOCK: begin
                nxt_gate = '0;
                if (pll_locked_i) begin
                    nxt_state = ST_RUN;
                    nxt_gate  = out_clock_enable_i;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff   <= ST_RUN;
            ref_sel_ff <= 1'b0;
            rst_ff     <= 1'b0;
            rst_cnt_ff <= 2'h0;
            pfd_ff     <= 1'b0;
            gate_ff    <= '0;
        end else begin
            state_ff   <= nxt_state;
            ref_sel_ff <= nxt_ref_sel;
            rst_ff     <= nxt_rst;
            rst_cnt_ff <= nxt_rst_cnt;
            pfd_ff     <= nxt_pfd;
            gate_ff    <= nxt_gate;
        end
    end

    assign ref_select_o     = ref_sel_ff;
    assign pll_reset_o      = rst_ff;
    assign pfd_enable_o     = pfd_ff;
    assign out_clock_gate_o = gate_ff;

    ////////////////////////////////////////////////////////////////////////////
    // dynamic phase stepping on oscillator taps, shift clock divider
    logic                 busy_ff, nxt_busy;
    logic                 done_ff, nxt_done;
    phase_cmd_t           cmd_ff, nxt_cmd;
    logic [1:0]           step_cnt_ff, nxt_step_cnt;
    logic                 scan_div_ff, nxt_scan_div;
    logic                 scan_ff, nxt_scan;
    logic [TAP_W-1:0]     tap_ff [NUM_OUT_COUNTERS];
    logic [TAP_W-1:0]     nxt_tap [NUM_OUT_COUNTERS];
    logic [COARSE_W-1:0]  coarse_ff [NUM_OUT_COUNTERS];
    logic [COARSE_W-1:0]  nxt_coarse [NUM_OUT_COUNTERS];
    logic                 accept;

    assign phase_ready_o = ~busy_ff;
    assign accept        = phase_cmd_i.req & ~busy_ff;

    always_comb begin
        nxt_busy     = busy_ff;
        nxt_done     = 1'b0;
        nxt_cmd      = cmd_ff;
        nxt_step_cnt = step_cnt_ff;
        nxt_scan_div = scan_div_ff + 1'b1;
        nxt_scan     = (int'(scan_div_ff) == SCAN_HALF_CYC - 1) ? ~scan_ff : scan_ff;
        nxt_tap      = tap_ff;
        nxt_coarse   = coarse_ff;
        if (accept) begin
            nxt_busy     = 1'b1;
            nxt_cmd      = phase_cmd_i;
            nxt_step_cnt = 2'h0;
        end else if (busy_ff) begin
            if (int'(step_cnt_ff) == SCAN_STEP_CYC - 1) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                for (int i = 0; i < NUM_OUT_COUNTERS; i++) begin
                    if (int'(cmd_ff.counter) == i) begin
                        nxt_tap[i] = cmd_ff.up ? tap_ff[i] + 3'h1 : tap_ff[i] - 3'h1;
                        if (cmd_ff.up && tap_ff[i] == TAP_LAST) begin
                            nxt_coarse[i] = coarse_ff[i] + 8'h01;
                        end else if (!cmd_ff.up && tap_ff[i] == TAP_RESET
                                     && coarse_ff[i] > COARSE_MIN) begin
                            nxt_coarse[i] = coarse_ff[i] - 8'h01;
                        end
                    end
                end
            end else begin
                nxt_step_cnt = step_cnt_ff + 2'h1;
            end
        end
        // a direct load of a starting value overrides a carry in the same cycle
        for (int i = 0; i < NUM_OUT_COUNTERS; i++) begin
            if (coarse_load_i && int'(coarse_counter_i) == i) begin
                nxt_coarse[i] = coarse_value_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
            cmd_ff      <= '0;
            step_cnt_ff <= 2'h0;
            scan_div_ff <= 1'b0;
            scan_ff     <= 1'b0;
            for (int i = 0; i < NUM_OUT_COUNTERS; i++) begin
                tap_ff[i]    <= TAP_RESET;
                coarse_ff[i] <= COARSE_RESET;
            end
        end else begin
            busy_ff     <= nxt_busy;
            done_ff     <= nxt_done;
            cmd_ff      <= nxt_cmd;
            step_cnt_ff <= nxt_step_cnt;
            scan_div_ff <= nxt_scan_div;
            scan_ff     <= nxt_scan;
            tap_ff      <= nxt_tap;
            coarse_ff   <= nxt_coarse;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_OUT_COUNTERS; i++) begin
            phase_tap_o[i*TAP_W +: TAP_W]          = tap_ff[i];
            coarse_start_o[i*COARSE_W +: COARSE_W] = coarse_ff[i];
        end
    end

    assign phase_done_o = done_ff;
    assign scan_clk_o   = scan_ff;

    ////////////////////////////////////////////////////////////////////////////
    // clock control block source selection
    logic [NUM_CCB_SRC-1:0]     src_vec;
    logic [NUM_DUAL_PURPOSE_CLOCK_PIN-1:0]       dp_vec;
    logic [NUM_CCB-1:0]         global_clock_net_ff, nxt_global_clock_net;
    logic [NUM_CORNER_PINS-1:0] gpio_ff, nxt_gpio;

    always_comb begin
        dp_vec    = dual_purpose_clock_pin_i;
        dp_vec[0] = corner_dual_purpose_clock_pin_i[corner_sel_i];
        src_vec   = {internal_clock_i, dp_vec, pll_counter_out_i, dedicated_clock_pin_i};
        nxt_gpio  = ~(4'h1 << corner_sel_i);
        for (int i = 0; i < NUM_CCB; i++) begin
            nxt_global_clock_net[i] = pick_src(src_vec, ccb_src_sel_i[i*SRC_SEL_W +: SRC_SEL_W]);
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            global_clock_net_ff <= '0;
            gpio_ff <= '1;
        end else begin
            global_clock_net_ff <= nxt_global_clock_net;
            gpio_ff <= nxt_gpio;
        end
    end

    assign global_clock_net_o = global_clock_net_ff;
    assign corner_gpio_o      = gpio_ff;
    assign status_o           = '{primary_fault:   fault_ff[0],
                                  secondary_fault: fault_ff[1],
                                  on_secondary:    ref_sel_ff,
                                  relocking:       state_ff != ST_RUN,
                                  phase_busy:      busy_ff};

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence switch_start_s;
        state_ff == ST_RUN && (manual_go || auto_go);
    endsequence
    sequence reset_hold_s;
        pll_reset_o [*3] ##1 !pll_reset_o && state_ff == ST_RELOCK;
    endsequence

    switch_reset_a: assert property (switch_start_s |=> ##1 reset_hold_s)
        else $error("switchover did not hold pll reset for three cycles");
    ref_toggle_a: assert property (switch_start_s |=> ref_select_o != $past(ref_select_o))
        else $error("reference select did not change on switchover");
    gate_relock_a: assert property (state_ff != ST_RUN |-> out_clock_gate_o == '0)
        else $error("output clock gate open during switchover");
    relock_exit_a: assert property (state_ff == ST_RELOCK && pll_locked_i
                                    |=> state_ff == ST_RUN
                                        && out_clock_gate_o == $past(out_clock_enable_i))
        else $error("gates not restored after lock");
    pfd_follow_a: assert property (!pfd_enable_i |=> !pfd_enable_o)
        else $error("phase detector left enabled");
    fault_set_a: assert property ($stable(primary_ref_clock_i) [*8]
                                  ##1 $stable(primary_ref_clock_i) [*8]
                                  ##1 $stable(primary_ref_clock_i) [*4]
                                  |-> ##1 primary_clock_fault_o)
        else $error("stopped primary reference not flagged");
    phase_step_a: assert property (accept |-> ##[1:5] phase_done_o)
        else $error("phase step not completed within one shift clock cycle");
    tap_move_a: assert property (phase_done_o && int'(cmd_ff.counter) < NUM_OUT_COUNTERS
                                 |-> phase_tap_o[cmd_ff.counter*TAP_W +: TAP_W]
                                     != $past(phase_tap_o[cmd_ff.counter*TAP_W +: TAP_W]))
        else $error("phase tap did not move by one step");
    // the first cycle after release still shows the all-free reset value
    corner_one_a: assert property ($past(nrst_i) |-> $onehot(~corner_gpio_o))
        else $error("more than one corner pin feeds clock control");
    ccb_pick_a: assert property ($past(nrst_i)
                                 && int'(ccb_src_sel_i[SRC_SEL_W-1:0]) < NUM_CCB_SRC
                                 |=> global_clock_net_o[0]
                                     == $past(src_vec[ccb_src_sel_i[SRC_SEL_W-1:0]]))
        else $error("clock control block 0 selected the wrong source");

endmodule : pll_switchover_ctrl

`default_nettype wire

/* File: test/pll_fabric_model.sv */
// behavioural reference clocks and pll lock indication facing the switchover block
`timescale 1ns/100ps
`default_nettype none

module pll_fabric_model #(
    parameter int HALF_CYC = 3,
    parameter int LOCK_CYC = 12
) (
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic run_primary_i,
    input  wire logic run_secondary_i,
    input  wire logic pll_reset_i,
    output var logic  primary_ref_clock_o,
    output var logic  secondary_ref_clock_o,
    output var logic  pll_locked_o
);
    int div_cnt;
    int lock_cnt;

    // both references keep toggling unless the bench stops one on purpose
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= 0;
            primary_ref_clock_o <= 1'b0;
            secondary_ref_clock_o <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == HALF_CYC - 1) ? 0 : div_cnt + 1;
            if (div_cnt == HALF_CYC - 1) begin
                primary_ref_clock_o <= primary_ref_clock_o ^ run_primary_i;
                secondary_ref_clock_o <= secondary_ref_clock_o ^ run_secondary_i;
            end
        end
    end

    // lock drops in pll reset and returns only after a relock time
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lock_cnt <= 0;
            pll_locked_o <= 1'b0;
        end else begin
            lock_cnt <= pll_reset_i ? 0 : ((lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt);
            pll_locked_o <= !pll_reset_i && (lock_cnt == LOCK_CYC);
        end
    end
endmodule : pll_fabric_model

`default_nettype wire

/* File: test/pll_switchover_ctrl_tb.sv */
// self-checking bench for the pll switchover control block
`timescale 1ns/100ps
`default_nettype none

module pll_switchover_ctrl_tb
    import pll_ctrl_pkg::*;
;
    logic        clock_i, nrst_i, run_pri, run_sec, pri_clk, sec_clk, locked;
    logic        manual_switch_i, auto_switch_en_i, pfd_enable_i, coarse_load_i;
    logic [4:0]  out_clock_enable_i, internal_clock_i, ccb_exp, out_clock_gate_o;
    logic [4:0]  global_clock_net_o;
    phase_cmd_t  phase_cmd_i;
    logic [2:0]  coarse_counter_i, tap_e;
    logic [7:0]  coarse_value_i, crs_e;
    logic [3:0]  dedicated_clock_pin_i, corner_dual_purpose_clock_pin_i, corner_gpio_o;
    logic [9:0]  pll_counter_out_i;
    logic [5:0]  dual_purpose_clock_pin_i;
    logic [1:0]  corner_sel_i;
    logic [24:0] ccb_src_sel_i, src;
    logic        ref_select_o, pll_reset_o, pfd_enable_o, pri_fault, sec_fault;
    logic        phase_ready_o, phase_done_o, scan_clk_o, scan_e;
    logic [14:0] phase_tap_o;
    logic [39:0] coarse_start_o, crs_vec;
    pll_status_t status_o;
    int          failures, comparisons;

    pll_switchover_ctrl u_dut (
        .clock_i, .nrst_i, .primary_ref_clock_i(pri_clk), .secondary_ref_clock_i(sec_clk),
        .manual_switch_i, .auto_switch_en_i, .pfd_enable_i, .pll_locked_i(locked),
        .out_clock_enable_i, .phase_cmd_i, .coarse_load_i, .coarse_counter_i,
        .coarse_value_i, .dedicated_clock_pin_i, .pll_counter_out_i, .dual_purpose_clock_pin_i,
        .corner_dual_purpose_clock_pin_i, .corner_sel_i, .internal_clock_i, .ccb_src_sel_i,
        .ref_select_o, .pll_reset_o, .pfd_enable_o, .out_clock_gate_o,
        .primary_clock_fault_o(pri_fault), .secondary_clock_fault_o(sec_fault), .phase_ready_o,
        .phase_done_o, .scan_clk_o, .phase_tap_o, .coarse_start_o, .global_clock_net_o,
        .corner_gpio_o, .status_o);

    pll_fabric_model u_model (
        .clock_i, .nrst_i, .run_primary_i(run_pri), .run_secondary_i(run_sec),
        .pll_reset_i(pll_reset_o), .primary_ref_clock_o(pri_clk),
        .secondary_ref_clock_o(sec_clk), .pll_locked_o(locked));

    always #2 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // one switchover, manual or automatic, then watch reset and lock wait
    task automatic run_switch(input logic use_auto, input logic exp_sel);
        int n_rst;
        int n;
        n_rst = 0;
        n = 0;
        @(posedge clock_i);
        auto_switch_en_i <= use_auto;
        manual_switch_i <= ~use_auto;
        @(posedge clock_i);
        auto_switch_en_i <= 1'b0;
        manual_switch_i <= 1'b0;
        @(negedge clock_i);
        check(ref_select_o, exp_sel);
        check(status_o.on_secondary, exp_sel);
        while (status_o.relocking === 1'b1 && n < 100) begin
            check(out_clock_gate_o, 5'h00);
            n_rst += int'(pll_reset_o === 1'b1);
            n++;
            @(negedge clock_i);
        end
        check(n_rst, RST_HOLD_CYC);
        check(out_clock_gate_o, out_clock_enable_i);
    endtask : run_switch

    task automatic phase_step(input logic up);
        int n;
        n = 0;
        @(posedge clock_i);
        phase_cmd_i <= '{1'b1, up, 3'h2};
        @(posedge clock_i);
        phase_cmd_i.req <= 1'b0;
        @(negedge clock_i);
        check(phase_ready_o, 1'b0);
        check(status_o.phase_busy, 1'b1);
        while (phase_done_o !== 1'b1 && n < 20) begin
            n++;
            @(negedge clock_i);
        end
        check(n, SCAN_STEP_CYC);
        if (up) begin
            crs_e += 8'(tap_e == TAP_LAST);
            tap_e++;
        end else begin
            crs_e -= 8'(tap_e == TAP_RESET && crs_e > COARSE_MIN);
            tap_e--;
        end
        crs_vec[23:16] = crs_e;
        check(phase_tap_o, 15'(tap_e) << 6);
        check(coarse_start_o, crs_vec);
        @(negedge clock_i);
        check(phase_done_o, 1'b0);
    endtask : phase_step

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        clock_i = 1'b0;
        nrst_i <= 1'b0;
        run_pri <= 1'b1;
        run_sec <= 1'b1;
        manual_switch_i <= 1'b0;
        auto_switch_en_i <= 1'b0;
        pfd_enable_i <= 1'b1;
        out_clock_enable_i <= 5'h1f;
        phase_cmd_i <= '0;
        coarse_load_i <= 1'b0;
        coarse_counter_i <= 3'h0;
        coarse_value_i <= 8'h00;
        dedicated_clock_pin_i <= 4'h5;
        pll_counter_out_i <= 10'h2b3;
        dual_purpose_clock_pin_i <= 6'h2a;
        corner_dual_purpose_clock_pin_i <= 4'h6;
        corner_sel_i <= 2'h0;
        internal_clock_i <= 5'h13;
        ccb_src_sel_i <= '0;
        tap_e = TAP_RESET;
        crs_e = COARSE_RESET;
        crs_vec = {5{COARSE_RESET}};
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        check(coarse_start_o, crs_vec);
        check({corner_gpio_o, phase_ready_o, pll_reset_o}, 6'h3e);
        @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        check({pri_fault, sec_fault, ref_select_o}, 3'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_i);
            pfd_enable_i <= k[0];
            out_clock_enable_i <= 5'h15 ^ {5{k[1]}};
            @(posedge clock_i);
            @(negedge clock_i);
            check(pfd_enable_o, k[0]);
            check(out_clock_gate_o, 5'h15 ^ {5{k[1]}});
            if (k > 0) check(scan_clk_o, !scan_e);
            scan_e = scan_clk_o;
        end
        // each block picks a different source index, 25 is out of range and drives low
        for (int k = 0; k < 26; k++) begin
            @(posedge clock_i);
            corner_sel_i <= k[1:0];
            for (int b = 0; b < 5; b++) ccb_src_sel_i[b*5+:5] <= 5'((k + b) % 26);
            @(posedge clock_i);
            @(negedge clock_i);
            src = {internal_clock_i, dual_purpose_clock_pin_i[5:1],
                   corner_dual_purpose_clock_pin_i[k[1:0]], pll_counter_out_i,
                   dedicated_clock_pin_i};
            for (int b = 0; b < 5; b++) ccb_exp[b] = ((k + b) % 26 < 25) ? src[(k + b) % 26] : 1'b0;
            check(global_clock_net_o, ccb_exp);
            check(corner_gpio_o, 4'(~(4'h1 << k[1:0])));
        end
        repeat (8) phase_step(1'b1);
        repeat (9) phase_step(1'b0);
        @(posedge clock_i);
        coarse_load_i <= 1'b1;
        coarse_counter_i <= 3'h4;
        coarse_value_i <= 8'h05;
        @(posedge clock_i);
        coarse_load_i <= 1'b0;
        @(negedge clock_i);
        crs_vec[39:32] = 8'h05;
        check(coarse_start_o, crs_vec);
        run_switch(1'b0, 1'b1);
        run_switch(1'b0, 1'b0);
        @(posedge clock_i);
        run_pri <= 1'b0;
        n = 0;
        while (pri_fault !== 1'b1 && n < 60) begin
            n++;
            @(negedge clock_i);
        end
        check(n >= FAULT_IDLE_CYC && n <= FAULT_IDLE_CYC + 8, 1'b1);
        check({sec_fault, status_o.primary_fault}, 2'h1);
        run_switch(1'b1, 1'b1);
        @(posedge clock_i);
        run_pri <= 1'b1;
        n = 0;
        while (pri_fault !== 1'b0 && n < 60) begin
            n++;
            @(negedge clock_i);
        end
        check(n <= 12, 1'b1);
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        failures++;
        final_report();
    end
endmodule : pll_switchover_ctrl_tb

`default_nettype wire
